// file: pkg/lcc_regs.svh
`ifndef LCC_REGS_SVH
`define LCC_REGS_SVH

`define LCC_NUM_CELLS   10
`define LCC_NUM_ROWS    6
`define LCC_NUM_ROUTE   8
`define LCC_LUT_W       16

`define LCC_OFF_CSRC0   8'h00
`define LCC_OFF_CSRC1   8'h04
`define LCC_OFF_CSRC2   8'h08
`define LCC_OFF_CUSE    8'h0C
`define LCC_OFF_STATUS  8'h10
`define LCC_OFF_LEVELS  8'h14
`define LCC_REGION_CFG  2'h1
`define LCC_REGION_SEL  2'h2

`define LCC_CS_A_ROW    0
`define LCC_CS_A_FALL   3
`define LCC_CS_B_ROW    4
`define LCC_CS_B_FALL   7
`define LCC_SLOT_W      8
`define LCC_SRC_W       7
`define LCC_LOC_W       6

`define LCC_CFG_LUT      0
`define LCC_CFG_ACLR_SEL 16
`define LCC_CFG_CLK_SEL  17
`define LCC_CFG_ARITH    18
`define LCC_CFG_REGCH    19
`define LCC_CFG_LUTCH    20
`define LCC_CFG_SYNC_EN  21
`define LCC_CFG_ALOAD_EN 22

`define LCC_CSRC_RST    32'h0000_0000
`define LCC_CUSE_RST    11'h000
`define LCC_CELL_RST    32'h0000_0000

`endif

// file: pkg/lcc_pkg.sv
`include "lcc_regs.svh"
package lcc_pkg;
   typedef enum logic [3:0] {
      LCC_CTL_CLK_A   = 4'h0,
      LCC_CTL_CLK_B   = 4'h1,
      LCC_CTL_ENA_A   = 4'h2,
      LCC_CTL_ENA_B   = 4'h3,
      LCC_CTL_ACLR_A  = 4'h4,
      LCC_CTL_ACLR_B  = 4'h5,
      LCC_CTL_SCLR    = 4'h6,
      LCC_CTL_ALOAD   = 4'h7,
      LCC_CTL_SLOAD   = 4'h8,
      LCC_CTL_ADDNSUB = 4'h9,
      LCC_CTL_CIN     = 4'hA
   } lcc_ctl_t;

   typedef struct packed {
      logic tick_a;
      logic tick_b;
      logic aclr_a;
      logic aclr_b;
      logic sclr;
      logic aload;
      logic sload;
      logic addnsub;
   } lcc_ctrl_t;

   typedef struct packed {
      logic                        cin;
      logic [`LCC_NUM_CELLS-1:0]   right;
      logic [`LCC_NUM_CELLS-1:0]   left;
      logic [`LCC_NUM_ROUTE-1:0]   route;
      logic [`LCC_NUM_ROWS-1:0]    row;
   } lcc_pins_t;

   typedef struct packed {
      logic        sel;
      logic        en;
      logic        wr;
      logic [7:0]  addr;
      logic [31:0] wdata;
   } lcc_apb_t;
endpackage

// file: hw/lcc_sync.sv
module lcc_sync
   import lcc_pkg::*;
(
   input  wire logic      clk_in,
   input  wire logic      rst_n_in,
   input  wire lcc_pins_t d_in,
   output lcc_pins_t      q_out
);
   lcc_pins_t meta_reg;
   lcc_pins_t sync_reg;

   // first stage is read by the second stage only
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         meta_reg <= '0;
         sync_reg <= '0;
      end else begin
         meta_reg <= d_in;
         sync_reg <= meta_reg;
      end
   end
   assign q_out = sync_reg;
endmodule

// file: hw/lcc_cell.sv
`include "lcc_regs.svh"
module lcc_cell
   import lcc_pkg::*;
(
   input  wire logic        clk_in,
   input  wire logic        rst_n_in,
   input  wire logic [31:0] cfg_in,
   input  wire logic [3:0]  data_in,
   input  wire lcc_ctrl_t   ctrl_in,
   input  wire logic        carry_in,
   input  wire logic        lut_chain_in,
   input  wire logic        reg_chain_in,
   output logic             lut_out,
   output logic             carry_out,
   output logic             q_out
);
   logic                  arith;
   logic                  tick;
   logic                  aclr;
   logic                  aload_hit;
   logic                  sclr_hit;
   logic                  sload_hit;
   logic                  opnd_b;
   logic                  d3;
   logic [`LCC_LUT_W-1:0] lut_mask;
   logic                  q_reg;

   assign arith     = cfg_in[`LCC_CFG_ARITH];
   assign tick      = cfg_in[`LCC_CFG_CLK_SEL] ? ctrl_in.tick_b
                                               : ctrl_in.tick_a;
   assign aclr      = cfg_in[`LCC_CFG_ACLR_SEL] ? ctrl_in.aclr_b
                                                : ctrl_in.aclr_a;
   assign aload_hit = cfg_in[`LCC_CFG_ALOAD_EN] & ctrl_in.aload;
   assign sclr_hit  = cfg_in[`LCC_CFG_SYNC_EN] & ctrl_in.sclr;
   assign sload_hit = cfg_in[`LCC_CFG_SYNC_EN] & ctrl_in.sload;
   assign opnd_b    = data_in[1] ^ (arith & ctrl_in.addnsub);
   assign d3        = cfg_in[`LCC_CFG_LUTCH] ? lut_chain_in : data_in[3];
   assign lut_mask  = cfg_in[`LCC_CFG_LUT +: `LCC_LUT_W];
   assign carry_out = (data_in[0] & opnd_b) |
                      (carry_in & (data_in[0] ^ opnd_b));
   assign lut_out   = arith ? (data_in[0] ^ opnd_b ^ carry_in)
                            : lut_mask[{d3, data_in[2:0]}];

   // clear beats preset; both act without waiting for a cluster clock
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         q_reg <= 1'b0;
      end else if (aclr) begin
         q_reg <= 1'b0;
      end else if (aload_hit) begin
         q_reg <= data_in[3];
      end else if (tick) begin
         if (sclr_hit) begin
            q_reg <= 1'b0;
         end else if (sload_hit) begin
            q_reg <= data_in[3];
         end else begin
            q_reg <= cfg_in[`LCC_CFG_REGCH] ? reg_chain_in : lut_out;
         end
      end
   end
   assign q_out = q_reg;

   default clocking @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);

   chk_preset_load: assert property (
      (!aclr && aload_hit && data_in[3]) |=> q_reg)
      else $error("load with data high did not preset");
   chk_sync_clear: assert property (
      (!aclr && !aload_hit && tick && sclr_hit) |=> !q_reg)
      else $error("synchronous clear missed on clock tick");
   chk_hold_no_tick: assert property (
      (!aclr && !aload_hit && !tick) |=> $stable(q_reg))
      else $error("register changed without a cluster clock");
endmodule

// file: hw/lcc_top.sv
// Behaviour
// - A cluster holds ten logic cells with carry, chains and control.
// - Ten controls at most: two clocks, enables, clears and four more.
// - Each cluster clock pairs with its own enable, a with a, b with b.
// - Both edges of one source take both cluster clocks, one each.
// - An inactive enable stops its cluster clock from capturing data.
// - Asynchronous load presets a register when its load data is high.
// - A cluster-wide select makes every cell in arithmetic mode (LCC_CFG_ARITH set) add or subtract at run time.
// - Controls come from the six row clock lines and local interconnect.
// - Local interconnect takes routing, own cells and both neighbours.
// - Register and lookup outputs chain to the adjacent cell.
// - Subtract inverts operand b and forces the first carry-in to one.
// - Synchronous clear and load act on registers whose cell sets LCC_CFG_SYNC_EN, on that cell's own clock.
`include "lcc_regs.svh"
module lcc_top
   import lcc_pkg::*;
(
   input  wire logic                      SYS_CLK_IN,
   input  wire logic                      RSTN_IN,
   input  wire logic                      PSEL_IN,
   input  wire logic                      PENABLE_IN,
   input  wire logic                      PWRITE_IN,
   input  wire logic [7:0]                PADDR_IN,
   input  wire logic [31:0]               PWDATA_IN,
   output logic      [31:0]               PRDATA_OUT,
   output logic                           PREADY_OUT,
   output logic                           PSLVERR_OUT,
   input  wire logic [`LCC_NUM_ROWS-1:0]  ROW_CLK_IN,
   input  wire logic [`LCC_NUM_ROUTE-1:0] ROUTE_IN,
   input  wire logic [`LCC_NUM_CELLS-1:0] LEFT_IN,
   input  wire logic [`LCC_NUM_CELLS-1:0] RIGHT_IN,
   input  wire logic                      CARRY_IN_IN,
   output logic      [`LCC_NUM_CELLS-1:0] Q_OUT,
   output logic      [`LCC_NUM_CELLS-1:0] LUT_OUT,
   output logic                           CARRY_OUT
);
   localparam int         NC  = `LCC_NUM_CELLS;
   localparam logic [3:0] NC4 = 4'(`LCC_NUM_CELLS);

   lcc_pins_t         pins_raw;
   lcc_pins_t         pins_s;
   lcc_apb_t          apb;
   logic [7:0]        row8;
   logic [7:0]        rowd8;
   logic [7:0]        rise8;
   logic [7:0]        fall8;
   logic [`LCC_NUM_ROWS-1:0] row_d_reg;
   logic [31:0]       csrc0_reg;
   logic [31:0]       csrc1_reg;
   logic [31:0]       csrc2_reg;
   logic [10:0]       cuse_reg;
   logic [31:0]       cfg_reg [NC];
   logic [31:0]       sel_reg [NC];
   logic [63:0]       local_bus;
   logic [127:0]      src_all;
   logic [63:0]       csrc;
   logic [7:0]        slot_raw;
   logic [2:0]        a_row;
   logic [2:0]        b_row;
   logic              ena_a;
   logic              ena_b;
   logic [9:0]        lvl;
   logic [3:0]        active_cnt;
   lcc_ctrl_t         ctrl;
   logic [NC:0]       carry;
   logic [NC-1:0]     lut_w;
   logic [NC-1:0]     q_w;
   logic [NC-1:0]     lut_chain;
   logic [NC-1:0]     reg_chain;
   logic [NC-1:0]     lut_reg;
   logic              carry_reg;
   logic [1:0]        region;
   logic [3:0]        idx;
   logic              cell_hit;
   logic              acc;
   logic              wr_fire;
   logic              unmapped;
   logic [31:0]       rdata_next;
   logic [31:0]       prdata_reg;
   logic              pready_reg;
   logic              pslverr_reg;

   // pins into the system clock domain
   assign pins_raw = {CARRY_IN_IN, RIGHT_IN, LEFT_IN, ROUTE_IN, ROW_CLK_IN};

   lcc_sync u_sync (
      .clk_in   (SYS_CLK_IN),
      .rst_n_in (RSTN_IN),
      .d_in     (pins_raw),
      .q_out    (pins_s)
   );

   always_ff @(posedge SYS_CLK_IN or negedge RSTN_IN) begin
      if (!RSTN_IN) begin
         row_d_reg <= '0;
      end else begin
         row_d_reg <= pins_s.row;
      end
   end

   // row lines act as clock sources; edges become one-cycle ticks
   assign row8  = {2'h0, pins_s.row};
   assign rowd8 = {2'h0, row_d_reg};
   assign rise8 = row8 & ~rowd8;
   assign fall8 = ~row8 & rowd8;

   // own cells feed back through registered copies to avoid loops
   assign local_bus = {16'h0000, q_w, lut_reg, pins_s.right, pins_s.left,
                       pins_s.route};
   assign src_all   = {56'h0, row8, local_bus};
   assign csrc      = {csrc2_reg, csrc1_reg};

   // control generation
   generate
      for (genvar j = 0; j < 8; j++) begin : g_slot
         assign slot_raw[j] =
            src_all[csrc[j*`LCC_SLOT_W +: `LCC_SRC_W]];
      end
   endgenerate

   assign a_row = csrc0_reg[`LCC_CS_A_ROW +: 3];
   assign b_row = csrc0_reg[`LCC_CS_B_ROW +: 3];
   // an enable left unused keeps its clock running
   assign ena_a = cuse_reg[LCC_CTL_ENA_A] ? slot_raw[0] : 1'b1;
   assign ena_b = cuse_reg[LCC_CTL_ENA_B] ? slot_raw[1] : 1'b1;

   always_comb begin
      ctrl.tick_a  = cuse_reg[LCC_CTL_CLK_A] & ena_a &
         (csrc0_reg[`LCC_CS_A_FALL] ? fall8[a_row] : rise8[a_row]);
      ctrl.tick_b  = cuse_reg[LCC_CTL_CLK_B] & ena_b &
         (csrc0_reg[`LCC_CS_B_FALL] ? fall8[b_row] : rise8[b_row]);
      ctrl.aclr_a  = cuse_reg[LCC_CTL_ACLR_A] & slot_raw[2];
      ctrl.aclr_b  = cuse_reg[LCC_CTL_ACLR_B] & slot_raw[3];
      ctrl.sclr    = cuse_reg[LCC_CTL_SCLR] & slot_raw[4];
      ctrl.aload   = cuse_reg[LCC_CTL_ALOAD] & slot_raw[5];
      ctrl.sload   = cuse_reg[LCC_CTL_SLOAD] & slot_raw[6];
      ctrl.addnsub = cuse_reg[LCC_CTL_ADDNSUB] & slot_raw[7];
   end

   assign lvl = {slot_raw, row8[b_row], row8[a_row]};

   always_comb begin
      active_cnt = 4'h0;
      for (int k = 0; k <= LCC_CTL_ADDNSUB; k++) begin
         active_cnt = active_cnt + {3'h0, cuse_reg[k]};
      end
   end

   // subtract forces the first carry-in high for two's complement
   assign carry[0] = ctrl.addnsub |
                     (cuse_reg[LCC_CTL_CIN] & pins_s.cin);

   // the ten cells and their chains
   assign lut_chain = {lut_w[NC-2:0], 1'b0};
   assign reg_chain = {q_w[NC-2:0], 1'b0};

   generate
      for (genvar i = 0; i < NC; i++) begin : g_cell
         logic [3:0] data;
         for (genvar k = 0; k < 4; k++) begin : g_in
            assign data[k] =
               local_bus[sel_reg[i][k*`LCC_SLOT_W +: `LCC_LOC_W]];
         end
         lcc_cell u_cell (
            .clk_in       (SYS_CLK_IN),
            .rst_n_in     (RSTN_IN),
            .cfg_in       (cfg_reg[i]),
            .data_in      (data),
            .ctrl_in      (ctrl),
            .carry_in     (carry[i]),
            .lut_chain_in (lut_chain[i]),
            .reg_chain_in (reg_chain[i]),
            .lut_out      (lut_w[i]),
            .carry_out    (carry[i+1]),
            .q_out        (q_w[i])
         );

         always_ff @(posedge SYS_CLK_IN or negedge RSTN_IN) begin
            if (!RSTN_IN) begin
               cfg_reg[i] <= `LCC_CELL_RST;
               sel_reg[i] <= `LCC_CELL_RST;
            end else if (wr_fire && cell_hit && idx == 4'(i)) begin
               if (region == `LCC_REGION_CFG) begin
                  cfg_reg[i] <= apb.wdata;
               end
               if (region == `LCC_REGION_SEL) begin
                  sel_reg[i] <= apb.wdata;
               end
            end
         end
      end
   endgenerate

   always_ff @(posedge SYS_CLK_IN or negedge RSTN_IN) begin
      if (!RSTN_IN) begin
         lut_reg   <= '0;
         carry_reg <= 1'b0;
      end else begin
         lut_reg   <= lut_w;
         carry_reg <= carry[NC];
      end
   end

   // apb slave, one wait state on every access
   assign apb      = {PSEL_IN, PENABLE_IN, PWRITE_IN, PADDR_IN, PWDATA_IN};
   assign region   = apb.addr[7:6];
   assign idx      = apb.addr[5:2];
   assign cell_hit = (idx < NC4) && (apb.addr[1:0] == 2'h0);
   assign acc      = apb.sel & apb.en & ~pready_reg;
   assign wr_fire  = apb.sel & apb.en & pready_reg & apb.wr & ~pslverr_reg;

   always_comb begin
      rdata_next = 32'h0000_0000;
      unmapped   = 1'b0;
      case (apb.addr)
         `LCC_OFF_CSRC0:  rdata_next = csrc0_reg;
         `LCC_OFF_CSRC1:  rdata_next = csrc1_reg;
         `LCC_OFF_CSRC2:  rdata_next = csrc2_reg;
         `LCC_OFF_CUSE:   rdata_next = {21'h0, cuse_reg};
         `LCC_OFF_STATUS: rdata_next = {11'h0, carry_reg, lut_reg, q_w};
         `LCC_OFF_LEVELS: rdata_next = {18'h0, active_cnt, lvl};
         default: begin
            if (cell_hit && region == `LCC_REGION_CFG) begin
               rdata_next = cfg_reg[idx];
            end else if (cell_hit && region == `LCC_REGION_SEL) begin
               rdata_next = sel_reg[idx];
            end else begin
               unmapped = 1'b1;
            end
         end
      endcase
   end

   always_ff @(posedge SYS_CLK_IN or negedge RSTN_IN) begin
      if (!RSTN_IN) begin
         pready_reg  <= 1'b0;
         pslverr_reg <= 1'b0;
         prdata_reg  <= 32'h0000_0000;
      end else begin
         pready_reg  <= acc;
         pslverr_reg <= acc & unmapped;
         if (acc && !apb.wr) begin
            prdata_reg <= rdata_next;
         end
      end
   end

   // status and level words are read only; writes there are dropped
   always_ff @(posedge SYS_CLK_IN or negedge RSTN_IN) begin
      if (!RSTN_IN) begin
         csrc0_reg <= `LCC_CSRC_RST;
         csrc1_reg <= `LCC_CSRC_RST;
         csrc2_reg <= `LCC_CSRC_RST;
         cuse_reg  <= `LCC_CUSE_RST;
      end else if (wr_fire) begin
         case (apb.addr)
            `LCC_OFF_CSRC0: csrc0_reg <= apb.wdata;
            `LCC_OFF_CSRC1: csrc1_reg <= apb.wdata;
            `LCC_OFF_CSRC2: csrc2_reg <= apb.wdata;
            `LCC_OFF_CUSE:  cuse_reg  <= apb.wdata[10:0];
            default:        cuse_reg  <= cuse_reg;
         endcase
      end
   end

   assign PRDATA_OUT  = prdata_reg;
   assign PREADY_OUT  = pready_reg;
   assign PSLVERR_OUT = pslverr_reg;
   assign Q_OUT       = q_w;
   assign LUT_OUT     = lut_reg;
   assign CARRY_OUT   = carry_reg;

   // checks
   default clocking @(posedge SYS_CLK_IN); endclocking
   default disable iff (!RSTN_IN);

   chk_clock_gate: assert property (
      (cuse_reg[LCC_CTL_ENA_A] && !slot_raw[0]) |-> !ctrl.tick_a)
      else $error("cluster clock a ticked while disabled");

   chk_pair_b: assert property (
      ctrl.tick_b |-> (ena_b && cuse_reg[LCC_CTL_CLK_B]))
      else $error("cluster clock b ticked without its enable");

   chk_edge_sel: assert property (
      ctrl.tick_a |-> (csrc0_reg[`LCC_CS_A_FALL]
         ? (rowd8[a_row] && !row8[a_row])
         : (!rowd8[a_row] && row8[a_row])))
      else $error("clock a tick on the wrong edge");

   chk_row_source: assert property (
      ctrl.tick_b |-> $past(pins_s.row) != pins_s.row)
      else $error("clock b tick without a row line change");

   chk_sub_carry: assert property (
      ctrl.addnsub |-> carry[0])
      else $error("subtract without forced carry-in");

   chk_unused_off: assert property (
      !cuse_reg[LCC_CTL_SCLR] |-> !ctrl.sclr ##1 active_cnt <= 4'hA)
      else $error("unused control asserted");

   chk_apb_ready: assert property (
      acc |=> pready_reg ##1 !pready_reg)
      else $error("apb answer not exactly one wait state");

   chk_cell_range: assert property (
      (acc && region == `LCC_REGION_CFG && idx >= NC4) |=> PSLVERR_OUT)
      else $error("cell index beyond ten not refused");

   chk_lut_mirror: assert property (
      ##1 lut_reg == $past(lut_w))
      else $error("lookup output copy lags");

   chk_edge_sel_b: assert property (
      ctrl.tick_b |-> (csrc0_reg[`LCC_CS_B_FALL]
         ? (rowd8[b_row] && !row8[b_row])
         : (!rowd8[b_row] && row8[b_row])))
      else $error("clock b tick on the wrong edge");

   chk_rdata_hold: assert property (
      !(acc && !apb.wr) |=> $stable(PRDATA_OUT))
      else $error("read data moved without a read");

   chk_err_ready: assert property (
      PSLVERR_OUT |-> PREADY_OUT)
      else $error("error flag without ready");

   chk_carry_mirror: assert property (
      ##1 carry_reg == $past(carry[NC]))
      else $error("carry out copy lags");

   chk_sel_range: assert property (
      (acc && region == `LCC_REGION_SEL && idx >= NC4) |=> PSLVERR_OUT)
      else $error("select index beyond ten not refused");

   cov_fall_clock: cover property (
      ctrl.tick_a && csrc0_reg[`LCC_CS_A_FALL]);
   cov_subtract: cover property (
      ctrl.addnsub && cfg_reg[0][`LCC_CFG_ARITH]);
   cov_sync_clear: cover property (ctrl.sclr && ctrl.tick_b);
   cov_apb_error: cover property (pready_reg && pslverr_reg);
   cov_async_load: cover property (
      ctrl.aload && cfg_reg[0][`LCC_CFG_ALOAD_EN]);
endmodule

// file: verif/lcc_far.sv
module lcc_far
   import lcc_pkg::*;
(
   input  wire logic clk_in,
   output lcc_pins_t pins_out
);
   timeunit 1ns;
   timeprecision 1ps;

   initial pins_out = '0;

   // lines only move right after an edge and then hold, like real fabric
   task automatic row(input int i, input logic v);
      @(posedge clk_in);
      pins_out.row[i] <= v;
   endtask

   task automatic route(input int i, input logic v);
      @(posedge clk_in);
      pins_out.route[i] <= v;
   endtask

   task automatic links(input logic l, input logic r);
      @(posedge clk_in);
      pins_out.left[0] <= l;
      pins_out.right[0] <= r;
   endtask
endmodule

// file: verif/tb.sv
`include "lcc_regs.svh"
module tb;
   import lcc_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;

   logic        clk;
   logic        rst_n;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [7:0]  paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        carry;
   logic [9:0]  q;
   logic [9:0]  lut;
   lcc_pins_t   pins;
   logic [31:0] rd;
   logic        er;
   int          err_total;
   int          total_checks;

   // address and data of the cluster set-up used by the cell tests
   localparam logic [39:0] CFG_TAB [11] = '{
      {8'h00, 32'h0000_0000}, {8'h04, 32'h0003_0001},
      {8'h08, 32'h0600_0502}, {8'h0C, 32'h0000_02D5},
      {8'h40, 32'h0060_AAAA}, {8'h80, 32'h0400_0000},
      {8'h44, 32'h0028_AAAA}, {8'h48, 32'h0000_AAAA},
      {8'h88, 32'h0000_0008}, {8'h4C, 32'h0000_AAAA},
      {8'h8C, 32'h0000_0012}};

   lcc_top dut_u (
      .SYS_CLK_IN  (clk),
      .RSTN_IN     (rst_n),
      .PSEL_IN     (psel),
      .PENABLE_IN  (penable),
      .PWRITE_IN   (pwrite),
      .PADDR_IN    (paddr),
      .PWDATA_IN   (pwdata),
      .PRDATA_OUT  (prdata),
      .PREADY_OUT  (pready),
      .PSLVERR_OUT (pslverr),
      .ROW_CLK_IN  (pins.row),
      .ROUTE_IN    (pins.route),
      .LEFT_IN     (pins.left),
      .RIGHT_IN    (pins.right),
      .CARRY_IN_IN (pins.cin),
      .Q_OUT       (q),
      .LUT_OUT     (lut),
      .CARRY_OUT   (carry));

   lcc_far far_u (.clk_in(clk), .pins_out(pins));

   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   task automatic close_out;
      if (err_total == 0 && total_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] seen,
                      input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] wd);
      int n;
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) begin
         err_total++;
         close_out();
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // row line 0 up, then down; synchronisers need a few edges each way
   task automatic pulse;
      far_u.row(0, 1'b1);
      repeat (8) @(posedge clk);
      far_u.row(0, 1'b0);
      repeat (8) @(posedge clk);
   endtask

   initial begin
      repeat (20000) @(posedge clk);
      err_total++;
      close_out();
   end

   initial begin
      logic [9:0]  av;
      logic [9:0]  bv;
      logic [10:0] sum;
      rst_n = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0000_0000;
      err_total = 0;
      total_checks = 0;
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      apb(1'b0, 8'h00, 32'h0);
      chk("csrc0_reset", rd, `LCC_CSRC_RST);
      apb(1'b0, 8'h0C, 32'h0);
      chk("cuse_reset", rd, {21'h0, `LCC_CUSE_RST});
      apb(1'b0, 8'h40, 32'h0);
      chk("cfg0_reset", rd, `LCC_CELL_RST);
      apb(1'b1, 8'h68, 32'hFFFF_FFFF);
      chk("unmapped_wr_err", {31'h0, er}, 32'h1);
      apb(1'b0, 8'h68, 32'h0);
      chk("unmapped_rd_err", {31'h0, er}, 32'h1);
      chk("unmapped_rd_data", rd, 32'h0);
      apb(1'b0, 8'hA8, 32'h0);
      chk("sel_range_err", {31'h0, er}, 32'h1);
      foreach (CFG_TAB[i]) begin
         apb(1'b1, CFG_TAB[i][39:32], CFG_TAB[i][31:0]);
         apb(1'b0, CFG_TAB[i][39:32], 32'h0);
         chk("cfg_readback", rd, CFG_TAB[i][31:0]);
      end
      far_u.links(1'b1, 1'b0);
      repeat (8) @(posedge clk);
      chk("left_link", {30'h0, lut[3:2]}, 32'h1);
      far_u.links(1'b0, 1'b1);
      repeat (8) @(posedge clk);
      chk("right_link", {30'h0, lut[3:2]}, 32'h2);
      far_u.links(1'b0, 1'b0);
      far_u.route(0, 1'b1);
      pulse();
      chk("q_enable_off", {22'h0, q}, 32'h0);
      far_u.route(1, 1'b1);
      pulse();
      chk("q_enable_on", {22'h0, q}, 32'h1);
      pulse();
      chk("q_reg_chain", {22'h0, q}, 32'h3);
      far_u.route(2, 1'b1);
      far_u.route(1, 1'b0);
      pulse();
      chk("sclr_gated", {22'h0, q}, 32'h3);
      far_u.route(1, 1'b1);
      pulse();
      chk("sclr_all", {22'h0, q}, 32'h0);
      far_u.route(2, 1'b0);
      // clock b takes the falling edge of the same row line
      apb(1'b1, 8'h00, 32'h0000_0080);
      apb(1'b1, 8'h0C, 32'h0000_02D7);
      apb(1'b1, 8'h44, 32'h002A_AAAA);
      far_u.row(0, 1'b1);
      repeat (8) @(posedge clk);
      chk("rise_clk_a", {22'h0, q}, 32'h1);
      far_u.row(0, 1'b0);
      repeat (8) @(posedge clk);
      chk("fall_clk_b", {22'h0, q}, 32'h3);
      far_u.route(3, 1'b1);
      repeat (8) @(posedge clk);
      chk("aclr", {22'h0, q}, 32'h0);
      far_u.route(3, 1'b0);
      far_u.route(4, 1'b1);
      far_u.route(5, 1'b1);
      repeat (8) @(posedge clk);
      chk("aload_preset", {22'h0, q}, 32'h1);
      far_u.route(5, 1'b0);
      far_u.route(4, 1'b0);
      for (int i = 0; i < 10; i++) begin
         apb(1'b1, 8'h40 + 8'(4 * i), 32'h0004_0000);
         apb(1'b1, 8'h80 + 8'(4 * i), 32'h0000_0007);
      end
      // every mix of all-zero/all-one operands, add and subtract
      for (int k = 0; k < 8; k++) begin
         far_u.route(7, k[0]);
         far_u.route(0, k[1]);
         far_u.route(6, k[2]);
         av = {10{k[0]}};
         bv = {10{k[1]}};
         if (k[2])
            sum = {1'b0, av} + {1'b0, ~bv} + 11'h001;
         else
            sum = {1'b0, av} + {1'b0, bv};
         repeat (8) @(posedge clk);
         chk("sum", {21'h0, carry, lut}, {21'h0, sum});
      end
      // last sum left carry out high, cell 0 still holds its preset
      apb(1'b0, `LCC_OFF_STATUS, 32'h0);
      chk("status", rd, 32'h0010_0001);
      // seven controls in use; slot levels follow the routing lines
      apb(1'b0, `LCC_OFF_LEVELS, 32'h0);
      chk("levels", rd, 32'h0000_1F2C);
      close_out();
   end
endmodule
